// ---- logic/ctrb_bank.sv ----
// Purpose: Offset and fine gain trim registers for the converter cores
// Assumes: APB slave on pclk; fuse values stable from reset release
// Notes:   Fuse copy takes one cycle after reset, bus stalls meanwhile
// Overview of operation
// - Core 3 input C uses its offset
// - Core 3 input D uses separate offset
// - Cores 4, 5 own offset each
// - Cores 0, 1, 4, 5 own gain
// - Core 2 gain follows input A/B
// - Core 3 gain follows input C/D
// - Copy cycle after reset loads trims from fuse storage
// - Offset trim is unsigned binary
`timescale 1ns/10ps
`default_nettype none
module ctrb_bank
    import ctrb_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [ctrb_pkg::CTRB_NOFS-1:0][ctrb_pkg::CTRB_OFS_W-1:0]
        fuse_offset,
    input wire logic [ctrb_pkg::CTRB_NGAIN-1:0][ctrb_pkg::CTRB_GAIN_W-1:0]
        fuse_gain,
    input wire logic core2_sample_b,
    input wire logic core3_sample_d,
    output logic [ctrb_pkg::CTRB_OFS_W-1:0] core3_offset,
    output logic [ctrb_pkg::CTRB_OFS_W-1:0] core4_offset,
    output logic [ctrb_pkg::CTRB_OFS_W-1:0] core5_offset,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core0_gain,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core1_gain,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core2_gain,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core3_gain,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core4_gain,
    output logic [ctrb_pkg::CTRB_GAIN_W-1:0] core5_gain
);
    import ctrb_pkg::*;

    ctrb_regs_t cur;
    ctrb_regs_t next_cur;
    logic hit;
    logic [3:0] slot;
    logic [2:0] gslot;
    logic setup;
    logic access;

    ctrb_decode u_decode (
        .paddr(paddr),
        .hit(hit),
        .slot(slot)
    );

    assign gslot = 3'(slot - 4'(CTRB_NOFS));
    assign setup = psel && !penable;
    assign access = psel && penable && (cur.state == CTRB_RUN);
    // Bus is held off while the fuse copy is in progress
    assign pready = (cur.state == CTRB_RUN);
    assign pslverr = psel && penable && pready && !hit;
    assign prdata = cur.prdata;

    always_comb begin
        next_cur = cur;
        case (cur.state)
            CTRB_LOAD: begin
                for (int i = 0; i < CTRB_NOFS; i++) begin
                    next_cur.ofs[i] = {4'h0, fuse_offset[i]};
                end
                for (int j = 0; j < CTRB_NGAIN; j++) begin
                    next_cur.gain[j] = {3'h0, fuse_gain[j]};
                end
                // read setup in copy cycle
                // A setup may land here; storage is not loaded yet, so the
                // fuse word being copied is returned instead
                if (setup && !pwrite) begin
                    if (!hit) begin
                        next_cur.prdata = 32'h0000_0000;
                    end else if (slot < 4'(CTRB_NOFS)) begin
                        next_cur.prdata = {20'h0_0000, fuse_offset[slot[1:0]]};
                    end else begin
                        next_cur.prdata = {27'h000_0000, fuse_gain[gslot]};
                    end
                end
                next_cur.state = CTRB_RUN;
            end
            CTRB_RUN: begin
                // Read data is captured in setup so it stands all access
                if (setup && !pwrite) begin
                    if (!hit) begin
                        next_cur.prdata = 32'h0000_0000;
                    end else if (slot < 4'(CTRB_NOFS)) begin
                        next_cur.prdata = {16'h0000, cur.ofs[slot[1:0]]};
                    end else begin
                        next_cur.prdata = {24'h00_0000, cur.gain[gslot]};
                    end
                end
                // Reserved bits are stored as written; keeping them zero
                // is up to software
                // reserved bits stored
                if (access && pwrite && hit) begin
                    if (slot < 4'(CTRB_NOFS)) begin
                        if (pstrb[0]) begin
                            next_cur.ofs[slot[1:0]][7:0] = pwdata[7:0];
                        end
                        if (pstrb[1]) begin
                            next_cur.ofs[slot[1:0]][15:8] = pwdata[15:8];
                        end
                    end else if (pstrb[0]) begin
                        next_cur.gain[gslot] = pwdata[7:0];
                    end
                end
            end
            default: begin
                next_cur.state = CTRB_LOAD;
            end
        endcase

        // input C offset / input D offset
        next_cur.app_ofs[0] = core3_sample_d
            ? cur.ofs[CTRB_O3D][CTRB_OFS_W-1:0]
            : cur.ofs[CTRB_O3C][CTRB_OFS_W-1:0];
        next_cur.app_ofs[1] = cur.ofs[CTRB_O4][CTRB_OFS_W-1:0];
        next_cur.app_ofs[2] = cur.ofs[CTRB_O5][CTRB_OFS_W-1:0];
        next_cur.app_gain[0] = cur.gain[CTRB_G0][CTRB_GAIN_W-1:0];
        next_cur.app_gain[1] = cur.gain[CTRB_G1][CTRB_GAIN_W-1:0];
        next_cur.app_gain[4] = cur.gain[CTRB_G4][CTRB_GAIN_W-1:0];
        next_cur.app_gain[5] = cur.gain[CTRB_G5][CTRB_GAIN_W-1:0];
        next_cur.app_gain[2] = core2_sample_b
            ? cur.gain[CTRB_G2B][CTRB_GAIN_W-1:0]
            : cur.gain[CTRB_G2A][CTRB_GAIN_W-1:0];
        next_cur.app_gain[3] = core3_sample_d
            ? cur.gain[CTRB_G3D][CTRB_GAIN_W-1:0]
            : cur.gain[CTRB_G3C][CTRB_GAIN_W-1:0];
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cur <= '{state: CTRB_LOAD,
                     ofs: {CTRB_NOFS{CTRB_OFS_RESET}},
                     gain: {CTRB_NGAIN{CTRB_GAIN_RESET}},
                     default: '0};
        end else begin
            cur <= next_cur;
        end
    end

    // Applied trims lag register and select changes by one cycle
    assign core3_offset = cur.app_ofs[0];
    assign core4_offset = cur.app_ofs[1];
    assign core5_offset = cur.app_ofs[2];
    assign core0_gain = cur.app_gain[0];
    assign core1_gain = cur.app_gain[1];
    assign core2_gain = cur.app_gain[2];
    assign core3_gain = cur.app_gain[3];
    assign core4_gain = cur.app_gain[4];
    assign core5_gain = cur.app_gain[5];
endmodule : ctrb_bank
`default_nettype wire

// ---- logic/ctrb_pkg.sv ----
// Purpose: Shared constants and types for the converter trim register bank
// Assumes: APB with 32-bit data, one register per aligned word
// Notes:   Register byte address is four times its printed index
package ctrb_pkg;

    localparam int CTRB_AW = 12;
    localparam int CTRB_NOFS = 4;
    localparam int CTRB_NGAIN = 8;
    localparam int CTRB_NREG = CTRB_NOFS + CTRB_NGAIN;
    localparam int CTRB_OFS_W = 12;
    localparam int CTRB_GAIN_W = 5;
    localparam int CTRB_OFS_REG_W = 16;
    localparam int CTRB_GAIN_REG_W = 8;

    // Printed register indices
    localparam logic [CTRB_AW-1:0] CORE3_INPUT_C_OFFSET_IDX = 12'h338;
    localparam logic [CTRB_AW-1:0] CORE3_INPUT_D_OFFSET_IDX = 12'h33a;
    localparam logic [CTRB_AW-1:0] CORE4_OFFSET_TRIM_IDX = 12'h33c;
    localparam logic [CTRB_AW-1:0] CORE5_OFFSET_TRIM_IDX = 12'h33e;
    localparam logic [CTRB_AW-1:0] CORE0_FINE_GAIN_IDX = 12'h360;
    localparam logic [CTRB_AW-1:0] CORE1_FINE_GAIN_IDX = 12'h361;
    localparam logic [CTRB_AW-1:0] CORE2_INPUT_A_FINE_GAIN_IDX = 12'h362;
    localparam logic [CTRB_AW-1:0] CORE2_INPUT_B_FINE_GAIN_IDX = 12'h363;
    localparam logic [CTRB_AW-1:0] CORE3_INPUT_C_FINE_GAIN_IDX = 12'h364;
    localparam logic [CTRB_AW-1:0] CORE3_INPUT_D_FINE_GAIN_IDX = 12'h365;
    localparam logic [CTRB_AW-1:0] CORE4_FINE_GAIN_IDX = 12'h366;
    localparam logic [CTRB_AW-1:0] CORE5_FINE_GAIN_IDX = 12'h367;

    // Slot order of the storage: four offsets, then eight gains
    localparam logic [CTRB_NREG-1:0][CTRB_AW-1:0] CTRB_REG_IDX = {
        CORE5_FINE_GAIN_IDX, CORE4_FINE_GAIN_IDX,
        CORE3_INPUT_D_FINE_GAIN_IDX, CORE3_INPUT_C_FINE_GAIN_IDX,
        CORE2_INPUT_B_FINE_GAIN_IDX, CORE2_INPUT_A_FINE_GAIN_IDX,
        CORE1_FINE_GAIN_IDX, CORE0_FINE_GAIN_IDX,
        CORE5_OFFSET_TRIM_IDX, CORE4_OFFSET_TRIM_IDX,
        CORE3_INPUT_D_OFFSET_IDX, CORE3_INPUT_C_OFFSET_IDX};

    // Gain slot numbers
    localparam int CTRB_G0 = 0;
    localparam int CTRB_G1 = 1;
    localparam int CTRB_G2A = 2;
    localparam int CTRB_G2B = 3;
    localparam int CTRB_G3C = 4;
    localparam int CTRB_G3D = 5;
    localparam int CTRB_G4 = 6;
    localparam int CTRB_G5 = 7;
    // Offset slot numbers
    localparam int CTRB_O3C = 0;
    localparam int CTRB_O3D = 1;
    localparam int CTRB_O4 = 2;
    localparam int CTRB_O5 = 3;

    localparam logic [15:0] CTRB_OFS_RESET = 16'h0000;
    localparam logic [7:0] CTRB_GAIN_RESET = 8'h00;

    typedef enum logic [1:0] {
        CTRB_LOAD = 2'b01,
        CTRB_RUN = 2'b10
    } ctrb_state_t;

    typedef struct packed {
        ctrb_state_t state;
        logic [CTRB_NOFS-1:0][CTRB_OFS_REG_W-1:0] ofs;
        logic [CTRB_NGAIN-1:0][CTRB_GAIN_REG_W-1:0] gain;
        logic [31:0] prdata;
        logic [2:0][CTRB_OFS_W-1:0] app_ofs;
        logic [5:0][CTRB_GAIN_W-1:0] app_gain;
    } ctrb_regs_t;

endpackage : ctrb_pkg

// ---- logic/ctrb_decode.sv ----
// Purpose: Address decoder for the trim register bank
// Assumes: Word-aligned APB byte addresses
// Notes:   Yields a hit flag and the storage slot of the addressed register
`timescale 1ns/10ps
`default_nettype none
module ctrb_decode
    import ctrb_pkg::*;
(
    input wire logic [13:0] paddr,
    output logic hit,
    output logic [3:0] slot
);
    logic [CTRB_NREG-1:0] match;

    genvar i;
    generate
        for (i = 0; i < CTRB_NREG; i++) begin : g_match
            assign match[i] = (paddr == {CTRB_REG_IDX[i], 2'b00});
        end
    endgenerate

    always_comb begin
        hit = |match;
        slot = 4'h0;
        for (int k = 0; k < CTRB_NREG; k++) begin
            if (match[k]) begin
                slot = 4'(k);
            end
        end
    end
endmodule : ctrb_decode
`default_nettype wire

// ---- verification/ctrb_bank_properties.sv ----
// Purpose: Port properties of the trim register bank
// Assumes: Writes carry full byte strobes
// Notes: Bound to ctrb_bank after the module
`timescale 1ns/10ps
`default_nettype none
module ctrb_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [13:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic pready,
    input wire logic [3:0][11:0] fuse_offset,
    input wire logic core2_sample_b,
    input wire logic core3_sample_d,
    input wire logic [11:0] core3_offset,
    input wire logic [11:0] core4_offset,
    input wire logic [4:0] core0_gain,
    input wire logic [4:0] core2_gain,
    input wire logic [4:0] core3_gain
);
    logic wr;
    assign wr = psel & penable & pready & pwrite;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_CORE3_INPUT_C_OFFSET: assert property (wr && paddr == 14'hce0
        ##1 !core3_sample_d |-> ##1 core3_offset == $past(pwdata[11:0], 2))
        else $error("core3_input_c_offset");
    AST_CORE3_INPUT_D_OFFSET: assert property (wr && paddr == 14'hce8
        ##1 core3_sample_d |-> ##1 core3_offset == $past(pwdata[11:0], 2))
        else $error("core3_input_d_offset");
    AST_CORE4_OFFSET_TRIM: assert property (wr && paddr == 14'hcf0
        |-> ##2 core4_offset == $past(pwdata[11:0], 2)) else $error("core4_offset_trim");
    AST_CORE0_FINE_GAIN: assert property (wr && paddr == 14'hd80
        |-> ##2 core0_gain == $past(pwdata[4:0], 2)) else $error("core0_fine_gain");
    AST_CORE2_INPUT_B_FINE_GAIN: assert property (wr && paddr == 14'hd8c
        ##1 core2_sample_b |-> ##1 core2_gain == $past(pwdata[4:0], 2))
        else $error("core2_input_b_fine_gain");
    AST_CORE3_INPUT_D_FINE_GAIN: assert property (wr && paddr == 14'hd94
        ##1 core3_sample_d |-> ##1 core3_gain == $past(pwdata[4:0], 2))
        else $error("core3_input_d_fine_gain");
    AST_FUSE: assert property ($rose(presetn)
        |-> ##2 core4_offset == fuse_offset[2]) else $error("fuse copy");
    // Bus stalls exactly for the one fuse copy cycle
    AST_LOAD_RDY: assert property ($rose(presetn) |-> !pready ##1 pready)
        else $error("load stall");
endmodule : ctrb_chk
bind ctrb_bank ctrb_chk i_ctrb_chk (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .pready, .fuse_offset, .core2_sample_b,
    .core3_sample_d, .core3_offset, .core4_offset, .core0_gain,
    .core2_gain, .core3_gain);
`default_nettype wire

// ---- verification/tb_top.sv ----
// Purpose: Self-checking bench for the trim register bank
// Assumes: Reserved bits written as zero; one partial strobe write
// Notes: Model is an int array of register words
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
    logic core2_sample_b, core3_sample_d;
    logic [13:0] paddr;
    logic [31:0] pwdata, prdata, r, seed, wdat;
    logic [3:0] pstrb;
    logic [3:0][11:0] fuse_offset;
    logic [7:0][4:0] fuse_gain;
    logic [11:0] core3_offset, core4_offset, core5_offset;
    logic [4:0] core0_gain, core1_gain, core2_gain, core3_gain;
    logic [4:0] core4_gain, core5_gain;
    int err_total, n_compared, i, s, pass;
    int model[12];
    ctrb_bank i_ctrb_bank (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .fuse_offset,
        .fuse_gain, .core2_sample_b, .core3_sample_d, .core3_offset,
        .core4_offset, .core5_offset, .core0_gain, .core1_gain, .core2_gain,
        .core3_gain, .core4_gain, .core5_gain);
    initial begin
        pclk = 0;
        forever #10 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    function automatic logic [13:0] ad(int k);
        return k < 4 ? 14'hce0 + 14'(8 * k) : 14'hd80 + 14'(4 * k - 16);
    endfunction : ad
    task automatic check(string nm, logic [31:0] sv, logic [31:0] xv);
        n_compared++;
        if (sv !== xv) begin
            err_total++;
            $display("wrong value %s exp %h got %h", nm, xv, sv);
        end
    endtask : check
    task automatic wrap_up();
        $display("compared %0d errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : wrap_up
    // Psel stays up so a next call starts its setup at once
    task automatic xfer(logic w, logic [13:0] a, logic [31:0] d);
        int n;
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        // Answer and read data are taken at the edge that sees pready
        for (n = 0; n < 50; n++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        r = prdata;
        e = pslverr;
        if (n == 50) begin
            err_total++;
            wrap_up();
        end
    endtask : xfer
    initial begin
        seed = 32'h3e3b;
        {presetn, psel, penable, pwrite, core2_sample_b, core3_sample_d} = 0;
        paddr = 0;
        pwdata = 0;
        pstrb = 4'hf;
        for (i = 0; i < 12; i++) model[i] = rnd() & (i < 4 ? 'hfff : 'h1f);
        for (i = 0; i < 4; i++) fuse_offset[i] = 12'(model[i]);
        for (i = 0; i < 8; i++) fuse_gain[i] = 5'(model[i + 4]);
        repeat (5) @(posedge pclk);
        presetn <= 1;
        repeat (3) @(posedge pclk);
        for (pass = 0; pass < 3; pass++) begin
            if (pass == 2) begin
                // Mid-run reset with new fuse values; the first read
                // setup then falls in the fuse copy cycle
                psel <= 0;
                penable <= 0;
                presetn <= 0;
                for (i = 0; i < 12; i++) begin
                    model[i] = rnd() & (i < 4 ? 'hfff : 'h1f);
                    if (i < 4) fuse_offset[i] <= 12'(model[i]);
                    else fuse_gain[i - 4] <= 5'(model[i]);
                end
                repeat (2) @(posedge pclk);
                presetn <= 1;
            end
            // access is held off only in the fuse copy cycle after reset
            // Select flips per write so both levels meet a fresh write
            for (i = 0; pass == 1 && i < 12; i++) begin
                core2_sample_b <= ~i[0];
                core3_sample_d <= ~i[0];
                model[i] = rnd() & (i < 4 ? 'hfff : 'h1f);
                xfer(1, ad(i), model[i]);
            end
            for (i = 0; i < 12; i++) begin
                xfer(0, ad(i), 0);
                check("rdata", r, model[i]);
                check("pslverr", e, 0);
            end
            psel <= 0;
            penable <= 0;
            for (s = 0; s < 4; s++) begin
                core2_sample_b <= s[0];
                core3_sample_d <= s[1];
                repeat (2) @(posedge pclk);
                @(negedge pclk);
                check("ofs3", core3_offset, model[s[1]]);
                check("ofs45", {core4_offset, core5_offset},
                    {model[2][11:0], model[3][11:0]});
                check("g0145", {core0_gain, core1_gain, core4_gain,
                    core5_gain}, {model[4][4:0], model[5][4:0],
                    model[10][4:0], model[11][4:0]});
                check("g2", core2_gain, model[6 + s[0]]);
                check("g3", core3_gain, model[8 + s[1]]);
                @(posedge pclk);
            end
        end
        xfer(1, 14'hce4, rnd());
        check("wr slverr", e, 1);
        xfer(0, 14'hce4, 0);
        check("unmapped", r, 0);
        check("slverr", e, 1);
        xfer(0, ad(0), 0);
        check("rdata", r, model[0]);
        // Only the upper lane of an offset word is written
        wdat = rnd() & 'hfff;
        model[3] = (model[3] & 'hff) | (wdat & 'hf00);
        pstrb <= 4'h2;
        xfer(1, ad(3), wdat);
        pstrb <= 4'hf;
        xfer(0, ad(3), 0);
        check("lane1", r, model[3]);
        wrap_up();
    end
endmodule : tb_top
`default_nettype wire
